// ---- logic/aperiodic_pkg.sv ----
// Constants and types shared by the aperiodic list register block and its FIFO.
// Assumes a 16-bit processor I/O port carrying command codes, then data words.
package aperiodic_pkg;
	localparam int WORD_W     = 16;
	localparam int MEM_ADDR_W = 11;
	localparam int INDEX_W    = 5;
	localparam int BLOCK_W    = 10;
	localparam int MAP_W      = 32;
	localparam int FIFO_DEPTH = 4;

	// Command codes, read side
	localparam logic [7:0] CMD_DONE_RD   = 8'h1B;
	localparam logic [7:0] CMD_SKIP_RD   = 8'h1C;
	localparam logic [7:0] CMD_LAST_RD   = 8'h1D;
	localparam logic [7:0] CMD_ACTIVE_RD = 8'h1E;
	localparam logic [7:0] CMD_BUFSZ_RD  = 8'h34;
	localparam logic [7:0] CMD_PORT_RD   = 8'h44;
	localparam logic [7:0] CMD_BLKSZ_RD  = 8'h54;
	// Command codes, write side
	localparam logic [7:0] CMD_SKIP_WR   = 8'h9C;
	localparam logic [7:0] CMD_LAST_WR   = 8'h9D;
	localparam logic [7:0] CMD_BUFSZ_WR  = 8'hB4;
	localparam logic [7:0] CMD_PORT_WR   = 8'hC4;
	localparam logic [7:0] CMD_BLKSZ_WR  = 8'hD4;

	// Reset values, buffer size limit and port step
	localparam logic [15:0] BUFSZ_RESET  = 16'h0200;
	localparam logic [15:0] BUFSZ_MAX    = 16'h1000;
	localparam logic [31:0] MAP_RESET    = 32'h0000_0000;
	localparam logic [9:0]  BLKSZ_RESET  = 10'h000;
	localparam logic [4:0]  INDEX_RESET  = 5'h00;
	localparam logic [15:0] PORT_START   = 16'h0000;
	localparam logic [15:0] PORT_STEP    = 16'h0002;

	typedef enum logic [1:0] {
		ST_IDLE       = 2'b00,
		ST_REG_ACCESS = 2'b01,
		ST_PORT_READ  = 2'b11,
		ST_PORT_WRITE = 2'b10
	} access_state_t;
endpackage

// ---- logic/word_stream_if.sv ----
// Valid/ready word stream between the register block and its FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface word_stream_if #(
	parameter int WIDTH = 16
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface // word_stream_if

// ---- logic/word_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-high reset.
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic   mclk,
	input  wire logic   rst,
	word_stream_if.sink   in_s,
	word_stream_if.source out_s
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wptr;
		logic [PW-1:0]               rptr;
		logic [CW-1:0]               count;
		logic                        full;
		logic                        empty;
	} fifo_t;

	fifo_t st_reg;
	fifo_t st_next;
	logic  push;
	logic  pop;

	assign push        = in_s.valid && !st_reg.full;
	assign pop         = out_s.ready && !st_reg.empty;
	assign in_s.ready  = !st_reg.full;
	assign out_s.valid = !st_reg.empty;
	assign out_s.data  = st_reg.mem[st_reg.rptr];

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wptr] = in_s.data;
			st_next.wptr = (st_reg.wptr == PW'(DEPTH - 1)) ? '0 : st_reg.wptr + 1'b1;
		end
		if (pop) begin
			st_next.rptr = (st_reg.rptr == PW'(DEPTH - 1)) ? '0 : st_reg.rptr + 1'b1;
		end
		if (push && !pop) begin
			st_next.count = st_reg.count + 1'b1;
		end else if (pop && !push) begin
			st_next.count = st_reg.count - 1'b1;
		end
		st_next.full  = (st_next.count == CW'(DEPTH));
		st_next.empty = (st_next.count == '0);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_reg       <= '0;
			st_reg.empty <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule // word_fifo

// ---- logic/aperiodic_list_buffer_regs.sv ----
// Aperiodic list register set: sizing, data port, done/skip/last maps, active index.
// Assumes a command/data processor port, an external buffer memory with a
// ready handshake and one-cycle read latency, and an external transaction engine.
`timescale 1ns/1ps
module aperiodic_list_buffer_regs
	import aperiodic_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  cmd_strobe,
	input  wire logic [7:0]            cmd_code,
	input  wire logic                  data_wr_strobe,
	input  wire logic [WORD_W-1:0]     port_word_in,
	input  wire logic                  data_rd_strobe,
	output logic      [WORD_W-1:0]     port_word_out,
	output logic                       port_word_valid,
	output logic                       port_wr_ready,
	input  wire logic [WORD_W-1:0]     transfer_byte_count,
	output logic                       all_transfers_ended_flag,
	output logic                       buffer_status_update,
	output logic      [MEM_ADDR_W-1:0] mem_addr,
	output logic                       mem_wr_en,
	output logic      [WORD_W-1:0]     mem_wdata,
	output logic                       mem_rd_en,
	input  wire logic                  mem_ready,
	input  wire logic [WORD_W-1:0]     mem_rdata,
	input  wire logic                  engine_done,
	input  wire logic                  engine_ack,
	input  wire logic                  engine_advance,
	output logic      [INDEX_W-1:0]    active_entry_index,
	output logic                       active_entry_skip,
	output logic      [WORD_W-1:0]     buffer_size_field,
	output logic      [BLOCK_W-1:0]    block_length_field
);
	typedef struct packed {
		access_state_t         state;
		logic                  write_dir;
		logic                  word_sel;
		logic [7:0]            code;
		logic [MAP_W-1:0]      hold;
		logic [WORD_W-1:0]     buffer_size;
		logic [BLOCK_W-1:0]    block_length;
		logic [MAP_W-1:0]      completion_bits;
		logic [MAP_W-1:0]      bypass_bits;
		logic [MAP_W-1:0]      final_entry_bits;
		logic [INDEX_W-1:0]    index;
		logic                  active_skip;
		logic [WORD_W-1:0]     byte_count;
		logic [WORD_W-1:0]     ptr;
		logic [WORD_W-1:0]     rd_data;
		logic                  rd_valid;
		logic                  rd_pending;
		logic [MEM_ADDR_W-1:0] mem_addr;
		logic                  mem_wr_en;
		logic                  mem_rd_en;
		logic [WORD_W-1:0]     mem_wdata;
		logic                  ended;
		logic                  status_update;
	} regs_t;

	regs_t st_reg;
	regs_t st_next;
	logic  drain_ok;

	word_stream_if #(.WIDTH(WORD_W)) in_s ();
	word_stream_if #(.WIDTH(WORD_W)) out_s ();

	// Read value of a register; reserved bits are forced to zero
	function automatic logic [MAP_W-1:0] read_value(input logic [7:0] code, input regs_t r);
		logic [MAP_W-1:0] v;
		v = '0;
		unique case (code)
			CMD_DONE_RD:   v = r.completion_bits;
			CMD_SKIP_RD:   v = r.bypass_bits;
			CMD_LAST_RD:   v = r.final_entry_bits;
			CMD_ACTIVE_RD: v = {{(MAP_W - INDEX_W){1'b0}}, r.index};
			CMD_BUFSZ_RD:  v = {{(MAP_W - WORD_W){1'b0}}, r.buffer_size};
			CMD_BLKSZ_RD:  v = {{(MAP_W - BLOCK_W){1'b0}}, r.block_length};
			default:       v = '0;
		endcase
		return v;
	endfunction

	function automatic logic is_reg_write(input logic [7:0] code);
		return (code == CMD_SKIP_WR) || (code == CMD_LAST_WR) ||
			(code == CMD_BUFSZ_WR) || (code == CMD_BLKSZ_WR);
	endfunction

	function automatic logic is_reg_read(input logic [7:0] code);
		return (code == CMD_DONE_RD) || (code == CMD_SKIP_RD) || (code == CMD_LAST_RD) ||
			(code == CMD_ACTIVE_RD) || (code == CMD_BUFSZ_RD) || (code == CMD_BLKSZ_RD);
	endfunction

	function automatic logic [INDEX_W-1:0] next_index(input logic [INDEX_W-1:0] idx,
		input logic [MAP_W-1:0] last_map);
		return last_map[idx] ? INDEX_RESET : idx + 1'b1;
	endfunction

	// Write path goes through the FIFO so a slow memory stalls the driver
	assign in_s.valid  = data_wr_strobe && (st_reg.state == ST_PORT_WRITE);
	assign in_s.data   = port_word_in;
	assign drain_ok    = !st_reg.mem_wr_en || mem_ready;
	assign out_s.ready = drain_ok && (st_reg.state == ST_PORT_WRITE);

	word_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk (mclk),
		.rst  (rst),
		.in_s (in_s),
		.out_s(out_s)
	);

	always_comb begin
		st_next               = st_reg;
		st_next.rd_valid      = 1'b0;
		st_next.ended         = 1'b0;
		st_next.status_update = 1'b0;

		// Memory handshakes
		if (st_reg.mem_wr_en && mem_ready) begin
			st_next.mem_wr_en = 1'b0;
		end
		if (st_reg.mem_rd_en && mem_ready) begin
			st_next.mem_rd_en  = 1'b0;
			st_next.rd_pending = 1'b1;
		end
		if (st_reg.rd_pending) begin
			st_next.rd_pending = 1'b0;
			st_next.rd_data    = mem_rdata;
			st_next.rd_valid   = 1'b1;
		end

		// Byte pointer; memory sees word addresses, wrapping at 4096 bytes
		// drain pointer advance
		if (out_s.valid && out_s.ready) begin
			st_next.mem_wr_en = 1'b1;
			st_next.mem_addr  = st_reg.ptr[MEM_ADDR_W:1];
			st_next.mem_wdata = out_s.data;
			st_next.ptr       = st_reg.ptr + PORT_STEP;
		end

		unique case (st_reg.state)
			ST_IDLE: begin
			end
			ST_REG_ACCESS: begin
				if (st_reg.write_dir && data_wr_strobe) begin
					st_next.word_sel = !st_reg.word_sel;
					// Low word first; 16-bit registers keep the first word only
					// reserved bits dropped
					unique case (st_reg.code)
						CMD_SKIP_WR: begin
							if (st_reg.word_sel) begin
								st_next.bypass_bits[31:16] = port_word_in;
							end else begin
								st_next.bypass_bits[15:0] = port_word_in;
							end
						end
						CMD_LAST_WR: begin
							if (st_reg.word_sel) begin
								st_next.final_entry_bits[31:16] = port_word_in;
							end else begin
								st_next.final_entry_bits[15:0] = port_word_in;
							end
						end
						CMD_BUFSZ_WR: begin
							if (!st_reg.word_sel) begin
								st_next.buffer_size = port_word_in;
							end
						end
						CMD_BLKSZ_WR: begin
							if (!st_reg.word_sel) begin
								st_next.block_length = port_word_in[BLOCK_W-1:0];
							end
						end
						default: begin
						end
					endcase
				end
				if (!st_reg.write_dir && data_rd_strobe) begin
					st_next.word_sel = !st_reg.word_sel;
					st_next.rd_data  = st_reg.word_sel ? st_reg.hold[31:16] : st_reg.hold[15:0];
					st_next.rd_valid = 1'b1;
				end
			end
			ST_PORT_READ: begin
				// One memory read in flight; strobes meanwhile are dropped
				// read pointer advance
				if (data_rd_strobe && !st_reg.mem_rd_en && !st_reg.rd_pending &&
					(st_reg.ptr < st_reg.byte_count)) begin
					st_next.mem_rd_en = 1'b1;
					st_next.mem_addr  = st_reg.ptr[MEM_ADDR_W:1];
					st_next.ptr       = st_reg.ptr + PORT_STEP;
				end
				if (!st_reg.mem_rd_en && (st_reg.ptr >= st_reg.byte_count)) begin
					st_next.state         = ST_IDLE;
					st_next.ended         = 1'b1;
					st_next.status_update = 1'b1;
				end
			end
			ST_PORT_WRITE: begin
				// Waits for the FIFO and the last memory write to drain
				// end of write transfer
				if ((st_reg.ptr >= st_reg.byte_count) && !out_s.valid && drain_ok) begin
					st_next.state         = ST_IDLE;
					st_next.ended         = 1'b1;
					st_next.status_update = 1'b1;
				end
			end
		endcase

		// Command decode; a new command aborts the previous access
		if (cmd_strobe) begin
			st_next.code     = cmd_code;
			st_next.word_sel = 1'b0;
			if (is_reg_read(cmd_code)) begin
				st_next.state     = ST_REG_ACCESS;
				st_next.write_dir = 1'b0;
				// Snapshot keeps both halves of a 32-bit read consistent
				st_next.hold      = read_value(cmd_code, st_reg);
				if (cmd_code == CMD_DONE_RD) begin
					st_next.completion_bits = MAP_RESET;
				end
			end else if (is_reg_write(cmd_code)) begin
				st_next.state     = ST_REG_ACCESS;
				st_next.write_dir = 1'b1;
			end else if ((cmd_code == CMD_PORT_RD) || (cmd_code == CMD_PORT_WR)) begin
				st_next.state      = (cmd_code == CMD_PORT_RD) ? ST_PORT_READ : ST_PORT_WRITE;
				st_next.ptr        = PORT_START;
				st_next.byte_count = transfer_byte_count;
			end else begin
				st_next.state = ST_IDLE;
			end
		end

		if (engine_done && engine_ack && !st_reg.bypass_bits[st_reg.index]) begin
			st_next.completion_bits[st_reg.index] = 1'b1;
		end

		if (engine_advance) begin
			st_next.index = next_index(st_reg.index, st_reg.final_entry_bits);
		end

		// The engine steps past a skipped entry itself; the index only counts
		// skip follows live map
		st_next.active_skip = st_next.bypass_bits[st_next.index];
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_reg                  <= '0;
			st_reg.state            <= ST_IDLE;
			st_reg.buffer_size      <= BUFSZ_RESET;
			st_reg.block_length     <= BLKSZ_RESET;
			st_reg.completion_bits  <= MAP_RESET;
			st_reg.bypass_bits      <= MAP_RESET;
			st_reg.final_entry_bits <= MAP_RESET;
			st_reg.index            <= INDEX_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign port_word_out            = st_reg.rd_data;
	assign port_word_valid          = st_reg.rd_valid;
	assign port_wr_ready            = in_s.ready;
	assign all_transfers_ended_flag = st_reg.ended;
	assign buffer_status_update     = st_reg.status_update;
	assign mem_addr                 = st_reg.mem_addr;
	assign mem_wr_en                = st_reg.mem_wr_en;
	assign mem_wdata                = st_reg.mem_wdata;
	assign mem_rd_en                = st_reg.mem_rd_en;
	assign active_entry_index       = st_reg.index;
	assign active_entry_skip        = st_reg.active_skip;
	assign buffer_size_field        = st_reg.buffer_size;
	assign block_length_field       = st_reg.block_length;
endmodule // aperiodic_list_buffer_regs

// ---- testbench/buffer_mem_model.sv ----
// Buffer memory on the far side of the block: ready handshake, read data one cycle later.
// Assumes word addresses and one clock; slow inserts three wait cycles in four.
`timescale 1ns/1ps
module buffer_mem_model
	import aperiodic_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  slow,
	input  wire logic [MEM_ADDR_W-1:0] mem_addr,
	input  wire logic                  mem_wr_en,
	input  wire logic [WORD_W-1:0]     mem_wdata,
	input  wire logic                  mem_rd_en,
	output logic                       mem_ready,
	output logic      [WORD_W-1:0]     mem_rdata
);
	logic [WORD_W-1:0] store [2**MEM_ADDR_W];
	logic [1:0]        phase;

	initial begin
		phase = 2'b00;
		mem_rdata = 16'h0000;
	end
	assign mem_ready = !slow || (phase == 2'b11);
	// Read data lasts one cycle, then toggles so stale values never match
	always @(posedge mclk) begin
		phase <= phase + 2'b01;
		mem_rdata <= ~mem_rdata;
		if (mem_wr_en && mem_ready)
			store[mem_addr] <= mem_wdata;
		if (mem_rd_en && mem_ready)
			mem_rdata <= store[mem_addr];
	end
endmodule // buffer_mem_model

// ---- testbench/aperiodic_list_buffer_regs_assertions.sv ----
// Timing checks on the ports of the aperiodic list register block.
// Assumes one clock domain; bound to the block below.
`timescale 1ns/1ps
module aperiodic_regs_checker
	import aperiodic_pkg::*;
(
	input wire logic                  mclk,
	input wire logic                  rst,
	input wire logic                  cmd_strobe,
	input wire logic [7:0]            cmd_code,
	input wire logic                  data_wr_strobe,
	input wire logic                  data_rd_strobe,
	input wire logic                  port_word_valid,
	input wire logic                  all_transfers_ended_flag,
	input wire logic                  buffer_status_update,
	input wire logic [MEM_ADDR_W-1:0] mem_addr,
	input wire logic                  mem_wr_en,
	input wire logic [WORD_W-1:0]     mem_wdata,
	input wire logic                  mem_rd_en,
	input wire logic                  mem_ready,
	input wire logic                  engine_advance,
	input wire logic [INDEX_W-1:0]    active_entry_index,
	input wire logic [WORD_W-1:0]     buffer_size_field,
	input wire logic [BLOCK_W-1:0]    block_length_field
);
	logic [MEM_ADDR_W-1:0] exp_addr_reg;
	logic                  reg_rd_reg;

	// Expected word address: zero at each command, one up per memory handshake
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			exp_addr_reg <= '0;
			reg_rd_reg   <= 1'b0;
		end else if (cmd_strobe) begin
			exp_addr_reg <= '0;
			reg_rd_reg   <= cmd_code inside {CMD_DONE_RD, CMD_SKIP_RD, CMD_LAST_RD,
				CMD_ACTIVE_RD, CMD_BUFSZ_RD, CMD_BLKSZ_RD};
		end else if ((mem_rd_en || mem_wr_en) && mem_ready) begin
			exp_addr_reg <= exp_addr_reg + 11'h001;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_ended_status;
		all_transfers_ended_flag |-> buffer_status_update;
	endproperty
	a_ended_status: assert property (p_ended_status)
		else $error("end flag without status update");
	property p_ended_pulse;
		all_transfers_ended_flag |=> !all_transfers_ended_flag;
	endproperty
	a_ended_pulse: assert property (p_ended_pulse)
		else $error("end flag longer than one cycle");
	property p_mem_addr;
		(mem_rd_en || mem_wr_en) |-> mem_addr == exp_addr_reg;
	endproperty
	a_mem_addr: assert property (p_mem_addr)
		else $error("buffer address not sequential from zero");
	property p_mem_hold;
		mem_wr_en && !mem_ready |=> mem_wr_en && $stable(mem_addr) && $stable(mem_wdata);
	endproperty
	a_mem_hold: assert property (p_mem_hold)
		else $error("memory write dropped before ready");
	property p_port_rd_valid;
		mem_rd_en && mem_ready |-> ##2 port_word_valid;
	endproperty
	a_port_rd_valid: assert property (p_port_rd_valid)
		else $error("port read word not delivered");
	property p_reg_rd_valid;
		reg_rd_reg && data_rd_strobe && !cmd_strobe |=> port_word_valid;
	endproperty
	a_reg_rd_valid: assert property (p_reg_rd_valid)
		else $error("register read word not delivered");
	property p_index_step;
		engine_advance |=> active_entry_index == $past(active_entry_index) + 5'h01
			|| active_entry_index == INDEX_RESET;
	endproperty
	a_index_step: assert property (p_index_step)
		else $error("index neither stepped nor wrapped");
	property p_index_hold;
		!engine_advance |=> $stable(active_entry_index);
	endproperty
	a_index_hold: assert property (p_index_hold)
		else $error("index moved without advance");
	property p_block_write;
		$changed(block_length_field) || $changed(buffer_size_field) |-> $past(data_wr_strobe);
	endproperty
	a_block_write: assert property (p_block_write)
		else $error("size field changed without a write");
endmodule // aperiodic_regs_checker

bind aperiodic_list_buffer_regs aperiodic_regs_checker i_aperiodic_regs_checker (
	.mclk, .rst, .cmd_strobe, .cmd_code, .data_wr_strobe, .data_rd_strobe,
	.port_word_valid, .all_transfers_ended_flag, .buffer_status_update, .mem_addr,
	.mem_wr_en, .mem_wdata, .mem_rd_en, .mem_ready, .engine_advance,
	.active_entry_index, .buffer_size_field, .block_length_field);

// ---- testbench/tb_aperiodic_list_buffer_regs.sv ----
// Bench for the aperiodic list register block through its command and data port.
// Assumes the buffer memory model; inputs change on falling edges.
`timescale 1ns/1ps
module tb_aperiodic_list_buffer_regs
	import aperiodic_pkg::*;
;
	logic mclk, rst, cmd_strobe, data_wr_strobe, data_rd_strobe;
	logic engine_done, engine_ack, engine_advance, mem_slow, saw_full;
	logic [7:0] cmd_code;
	logic [WORD_W-1:0] port_word_in, transfer_byte_count, port_word_out, w16, mem_wdata, mem_rdata;
	logic [MEM_ADDR_W-1:0] mem_addr;
	logic port_word_valid, port_wr_ready, all_transfers_ended_flag, buffer_status_update;
	logic mem_wr_en, mem_rd_en, mem_ready, active_entry_skip;
	logic [INDEX_W-1:0] active_entry_index;
	logic [WORD_W-1:0] buffer_size_field;
	logic [BLOCK_W-1:0] block_length_field;
	logic [31:0] rv;
	int mismatches, checks_done, ended_count, status_count, i;
	logic [7:0] rcode [6] = '{CMD_BUFSZ_RD, CMD_BLKSZ_RD, CMD_DONE_RD, CMD_SKIP_RD,
		CMD_LAST_RD, CMD_ACTIVE_RD};
	int rwords [6] = '{1, 1, 2, 2, 2, 1};
	logic [31:0] rexp [6] = '{{16'h0000, BUFSZ_RESET}, {22'h000000, BLKSZ_RESET},
		MAP_RESET, MAP_RESET, MAP_RESET, {27'h0000000, INDEX_RESET}};

	aperiodic_list_buffer_regs i_aperiodic_list_buffer_regs (.mclk(mclk), .rst(rst),
		.cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .data_wr_strobe(data_wr_strobe),
		.port_word_in(port_word_in), .data_rd_strobe(data_rd_strobe),
		.port_word_out(port_word_out), .port_word_valid(port_word_valid),
		.port_wr_ready(port_wr_ready), .transfer_byte_count(transfer_byte_count),
		.all_transfers_ended_flag(all_transfers_ended_flag),
		.buffer_status_update(buffer_status_update), .mem_addr(mem_addr),
		.mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .mem_rd_en(mem_rd_en),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata), .engine_done(engine_done),
		.engine_ack(engine_ack), .engine_advance(engine_advance),
		.active_entry_index(active_entry_index), .active_entry_skip(active_entry_skip),
		.buffer_size_field(buffer_size_field), .block_length_field(block_length_field));
	buffer_mem_model i_buffer_mem_model (.mclk(mclk), .slow(mem_slow), .mem_addr(mem_addr),
		.mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .mem_rd_en(mem_rd_en),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata));

	always @(posedge mclk) begin
		if (all_transfers_ended_flag === 1'b1)
			ended_count++;
		if (port_wr_ready === 1'b0)
			saw_full = 1'b1;
		if (buffer_status_update === 1'b1)
			status_count++;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic hang(input int n);
		if (n >= 60) begin
			mismatches++;
			$display("Error at %0t: wait ran out", $time);
			complete_run();
		end
	endtask
	// Tasks start and end just after a falling edge
	task automatic tick();
		@(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic cmd(input logic [7:0] code);
		cmd_strobe = 1'b1;
		cmd_code = code;
		tick();
		cmd_strobe = 1'b0;
	endtask
	task automatic rd_word(output logic [15:0] w);
		int n;
		data_rd_strobe = 1'b1;
		tick();
		data_rd_strobe = 1'b0;
		for (n = 0; n < 60 && port_word_valid !== 1'b1; n++)
			tick();
		hang(n);
		w = port_word_out;
	endtask
	// Strobe stays high between back-to-back words unless the FIFO is full; the caller lowers it
	task automatic wr_word(input logic [15:0] w);
		int n;
		for (n = 0; n < 60 && port_wr_ready !== 1'b1; n++) begin
			data_wr_strobe = 1'b0;
			tick();
		end
		hang(n);
		data_wr_strobe = 1'b1;
		port_word_in = w;
		tick();
	endtask
	task automatic rd_reg(input logic [7:0] code, input int words, output logic [31:0] v);
		logic [15:0] w;
		cmd(code);
		rd_word(w);
		v = {16'h0000, w};
		if (words == 2) begin
			tick();
			rd_word(w);
			v[31:16] = w;
		end
	endtask
	task automatic wr_reg(input logic [7:0] code, input logic [31:0] v, input int words);
		cmd(code);
		wr_word(v[15:0]);
		if (words == 2)
			wr_word(v[31:16]);
		data_wr_strobe = 1'b0;
	endtask
	task automatic eng(input logic done, input logic ack, input logic adv);
		engine_done = done;
		engine_ack = ack;
		engine_advance = adv;
		tick();
		{engine_done, engine_ack, engine_advance} = 3'b000;
		tick();
	endtask
	task automatic wait_end(input int target);
		int n;
		for (n = 0; n < 60 && ended_count != target; n++)
			tick();
		hang(n);
	endtask

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		{rst, saw_full, mem_slow} = 3'b100;
		{cmd_strobe, data_wr_strobe, data_rd_strobe} = 3'b000;
		{engine_done, engine_ack, engine_advance} = 3'b000;
		{cmd_code, port_word_in, transfer_byte_count} = 40'h00_0000_0000;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		for (i = 0; i < 6; i++) begin
			rd_reg(rcode[i], rwords[i], rv);
			check(rv, rexp[i]);
		end
		$display("test reset values done");
		wr_reg(CMD_BUFSZ_WR, {16'h0000, BUFSZ_MAX}, 1);
		rd_reg(CMD_BUFSZ_RD, 1, rv);
		check(rv, {16'h0000, BUFSZ_MAX});
		check(buffer_size_field, BUFSZ_MAX);
		wr_reg(CMD_BLKSZ_WR, 32'h0000_FFF8, 1);
		rd_reg(CMD_BLKSZ_RD, 1, rv);
		check(rv, 32'h0000_03F8);
		check(block_length_field, 10'h3F8);
		wr_reg(CMD_SKIP_WR, 32'h8000_0001, 2);
		rd_reg(CMD_SKIP_RD, 2, rv);
		check(rv, 32'h8000_0001);
		wr_reg(CMD_LAST_WR, 32'h0000_0004, 2);
		rd_reg(CMD_LAST_RD, 2, rv);
		check(rv, 32'h0000_0004);
		$display("test register access done");
		check(active_entry_skip, 1'b1);
		eng(1'b1, 1'b1, 1'b0);
		wr_reg(CMD_SKIP_WR, 32'h0000_0000, 2);
		check(active_entry_skip, 1'b0);
		eng(1'b1, 1'b1, 1'b0);
		eng(1'b0, 1'b0, 1'b1);
		eng(1'b1, 1'b0, 1'b0);
		eng(1'b0, 1'b0, 1'b1);
		rd_reg(CMD_ACTIVE_RD, 1, rv);
		check(rv, 32'h0000_0002);
		eng(1'b1, 1'b1, 1'b0);
		eng(1'b0, 1'b0, 1'b1);
		check(active_entry_index, 5'h00);
		rd_reg(CMD_DONE_RD, 2, rv);
		check(rv, 32'h0000_0005);
		rd_reg(CMD_DONE_RD, 2, rv);
		check(rv, MAP_RESET);
		{engine_done, engine_ack} = 2'b11;
		cmd(CMD_DONE_RD);
		{engine_done, engine_ack} = 2'b00;
		tick();
		rd_reg(CMD_DONE_RD, 2, rv);
		check(rv, 32'h0000_0001);
		$display("test descriptor maps done");
		transfer_byte_count = 16'h0010;
		mem_slow = 1'b1;
		cmd(CMD_PORT_WR);
		for (i = 0; i < 8; i++)
			wr_word({12'hA00, 4'(i)});
		data_wr_strobe = 1'b0;
		mem_slow = 1'b0;
		wait_end(1);
		check(saw_full, 1'b1);
		cmd(CMD_PORT_RD);
		mem_slow = 1'b1;
		for (i = 0; i < 8; i++) begin
			rd_word(w16);
			check(w16, {12'hA00, 4'(i)});
		end
		wait_end(2);
		transfer_byte_count = 16'h0002;
		cmd(CMD_PORT_RD);
		rd_word(w16);
		check(w16, 16'hA000);
		wait_end(3);
		check(ended_count, 32'd3);
		check(status_count, 32'd3);
		$display("test data port done");
		complete_run();
	end
endmodule // tb_aperiodic_list_buffer_regs
